// ---- pkg/pmr_pkg.sv ----
// constants, field layouts and carriers for the per-port phy management registers
// assumes a 25 MHz device clock and a management frame port sampled on that clock
package pmr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         PMR_ADDR_W      = 5;
    localparam int         PMR_REG_W       = 16;
    localparam logic [4:0] PMR_REG_CONTROL = 5'h00;
    localparam logic [4:0] PMR_REG_STATUS  = 5'h01;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int PMR_CTL_SRESET  = 15;
    localparam int PMR_CTL_LOOP    = 14;
    localparam int PMR_CTL_SPEED   = 13;
    localparam int PMR_CTL_AN_EN   = 12;
    localparam int PMR_CTL_PWRDN   = 11;
    localparam int PMR_CTL_ISOLATE = 10;
    localparam int PMR_CTL_AN_RST  = 9;
    localparam int PMR_CTL_DUPLEX  = 8;

    localparam logic PMR_LOOP_RST   = 1'b0;
    localparam logic PMR_SPEED_RST  = 1'b1;
    localparam logic PMR_AN_EN_RST  = 1'b1;
    localparam logic PMR_ISO_RST    = 1'b0;
    localparam logic PMR_DUPLEX_RST = 1'b0;
    localparam logic PMR_PRE_RST    = 1'b0;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int PMR_STS_PRE_SUP = 6;
    localparam int PMR_STS_AN_DONE = 5;
    localparam int PMR_STS_RFAULT  = 4;
    localparam int PMR_STS_LINK    = 2;
    localparam int PMR_STS_JABBER  = 1;

    // fixed capability bits: 14..11, 3 and 0 set, 15 clear
    localparam logic [15:0] PMR_STS_CAPS = 16'h7809;
    localparam logic [15:0] PMR_ZERO16   = 16'h0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int PMR_CLK_PERIOD_NS  = 40;
    localparam int PMR_SRESET_NS      = 1000;
    localparam int PMR_SRESET_CYCLES  = (PMR_SRESET_NS + PMR_CLK_PERIOD_NS - 1)
                                        / PMR_CLK_PERIOD_NS;
    localparam int PMR_AN_RST_CYCLES  = 2;

    // ----------------------------------------------------------------
    // management frame layout
    // ----------------------------------------------------------------
    localparam int         PMR_PRE_FULL  = 32;
    localparam int         PMR_PRE_SUPP  = 2;
    localparam int         PMR_HDR_BITS  = 13;
    localparam int         PMR_TA_BITS   = 2;
    localparam int         PMR_DATA_BITS = 16;
    localparam logic [1:0] PMR_OP_READ   = 2'h2;
    localparam logic [1:0] PMR_OP_WRITE  = 2'h1;

    typedef enum logic [2:0] {
        PMR_FR_PRE,
        PMR_FR_HDR,
        PMR_FR_TA,
        PMR_FR_RD,
        PMR_FR_WR
    } pmr_frame_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic an_enabled;
        logic an_restart;
        logic speed_100;
        logic full_duplex;
        logic isolate;
        logic preamble_suppress;
    } pmr_ctrl_s;

    typedef struct packed {
        logic link_pass;
        logic jabber;
        logic far_fault;
        logic an_complete;
        logic fiber_mode;
        logic ten_base_t;
    } pmr_line_s;

endpackage : pmr_pkg

// ---- rtl/pmr_sync3.sv ----
// three-stage input synchroniser, one lane per bit
// assumes inputs are asynchronous to clk; output moves once stages two and three agree
`timescale 1ns/1ps
module pmr_sync3
    import pmr_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic q_r;

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    q_r  <= 1'b0;
                end
                else if (clk_en)
                begin
                    s1_r <= d[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r)
                    begin
                        q_r <= s3_r;
                    end
                end
            end

            assign q[i] = q_r;
        end
    endgenerate

endmodule : pmr_sync3

// ---- rtl/pmr_regs.sv ----
// per-port phy control and status registers behind a serial management port
// assumes mdc is well below clk/4; line status comes from logic on clk
`timescale 1ns/1ps
module pmr_regs
    import pmr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR      = 5'h00,
    parameter int         SRESET_CYCLES = PMR_SRESET_CYCLES
)
(
    input  wire logic      clk,
    input  wire logic      reset,
    input  wire logic      clk_en,
    input  wire logic      mdc,
    input  wire logic      mdio_in,
    output logic           mdio_out,
    output logic           mdio_oe_n,
    input  wire logic      autoneg_enable_pin,
    input  wire logic      aux_restart_req,
    input  pmr_line_s      line,
    output pmr_ctrl_s      ctrl
);

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       mdc_s;
    logic       mdio_s;
    logic       an_pin_s;
    logic       mdc_prev_r;
    logic       mdc_rise;

    pmr_sync3 #(.W(3)) u_sync
    (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .d      ({mdc, mdio_in, autoneg_enable_pin}),
        .q      (pins_s)
    );

    assign mdc_s    = pins_s[2];
    assign mdio_s   = pins_s[1];
    assign an_pin_s = pins_s[0];
    assign mdc_rise = mdc_s & ~mdc_prev_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mdc_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            mdc_prev_r <= mdc_s;
        end
    end

    // ----------------------------------------------------------------
    // register state declarations
    // ----------------------------------------------------------------
    // soft reset counter sized from the parameter so long settings are not cut short
    localparam int SR_W = $clog2(SRESET_CYCLES + 1);

    logic [SR_W-1:0] sr_cnt_r;
    logic        loop_r;
    logic        speed_r;
    logic        an_sw_r;
    logic        iso_r;
    logic        dup_r;
    logic [1:0]  an_rst_cnt_r;
    logic        pre_sup_r;
    logic        rf_r;
    logic        link_low_r;
    logic        jab_r;
    logic        link_prev_r;
    logic [2:0]  snap_r;
    logic        sr_busy;
    logic        an_en;
    logic [15:0] ctl_rd;
    logic [15:0] sts_rd;

    // ----------------------------------------------------------------
    // management frame receiver and transmitter
    // ----------------------------------------------------------------
    pmr_frame_e  fr_r;
    logic [5:0]  pre_cnt_r;
    logic [4:0]  bit_cnt_r;
    logic [11:0] hdr_r;
    logic [12:0] hdr_nxt;
    logic [4:0]  reg_r;
    logic        is_read_r;
    logic [15:0] rd_shift_r;
    logic [14:0] wr_shift_r;
    logic        mdio_out_r;
    logic        drive_r;
    logic [5:0]  pre_need;
    logic        hdr_last;
    logic        hdr_ok;
    logic        rd_start;
    logic        rd_end;
    logic        wr_commit;
    logic [15:0] wr_data;
    logic [15:0] rd_mux;

    assign pre_need  = pre_sup_r ? 6'(PMR_PRE_SUPP) : 6'(PMR_PRE_FULL);
    assign hdr_nxt   = {hdr_r, mdio_s};
    assign hdr_last  = (fr_r == PMR_FR_HDR) && (bit_cnt_r == 5'(PMR_HDR_BITS - 1));
    // start bit 0 was taken at preamble end; hdr_nxt[12] is the second start bit
    assign hdr_ok    = hdr_nxt[12] && (hdr_nxt[9:5] == PHY_ADDR)
                       && ((hdr_nxt[11:10] == PMR_OP_READ) || (hdr_nxt[11:10] == PMR_OP_WRITE));
    assign rd_start  = mdc_rise && hdr_last && hdr_ok && (hdr_nxt[11:10] == PMR_OP_READ);
    assign rd_end    = mdc_rise && (fr_r == PMR_FR_RD)
                       && (bit_cnt_r == 5'(PMR_DATA_BITS));
    assign wr_commit = mdc_rise && (fr_r == PMR_FR_WR)
                       && (bit_cnt_r == 5'(PMR_DATA_BITS - 1));
    assign wr_data   = {wr_shift_r, mdio_s};
    assign rd_mux    = (hdr_nxt[4:0] == PMR_REG_CONTROL) ? ctl_rd
                     : (hdr_nxt[4:0] == PMR_REG_STATUS)  ? sts_rd
                     : PMR_ZERO16;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fr_r       <= PMR_FR_PRE;
            pre_cnt_r  <= 6'h00;
            bit_cnt_r  <= 5'h00;
            hdr_r      <= 12'h000;
            reg_r      <= 5'h00;
            is_read_r  <= 1'b0;
            rd_shift_r <= 16'h0000;
            wr_shift_r <= 15'h0000;
            mdio_out_r <= 1'b1;
            drive_r    <= 1'b0;
        end
        else if (clk_en && mdc_rise)
        begin
            case (fr_r)
                PMR_FR_PRE:
                begin
                    if (mdio_s)
                    begin
                        if (pre_cnt_r != 6'(PMR_PRE_FULL))
                        begin
                            pre_cnt_r <= pre_cnt_r + 6'h01;
                        end
                    end
                    else if (pre_cnt_r >= pre_need)
                    begin
                        fr_r      <= PMR_FR_HDR;
                        bit_cnt_r <= 5'h00;
                        pre_cnt_r <= 6'h00;
                    end
                    else
                    begin
                        pre_cnt_r <= 6'h00;
                    end
                end
                PMR_FR_HDR:
                begin
                    hdr_r     <= hdr_nxt[11:0];
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (hdr_last)
                    begin
                        bit_cnt_r  <= 5'h00;
                        reg_r      <= hdr_nxt[4:0];
                        is_read_r  <= (hdr_nxt[11:10] == PMR_OP_READ);
                        rd_shift_r <= rd_mux;
                        fr_r       <= hdr_ok ? PMR_FR_TA : PMR_FR_PRE;
                    end
                end
                PMR_FR_TA:
                begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (is_read_r)
                    begin
                        // drive the second turnaround bit low
                        drive_r    <= 1'b1;
                        mdio_out_r <= 1'b0;
                        bit_cnt_r  <= 5'h00;
                        fr_r       <= PMR_FR_RD;
                    end
                    else if (bit_cnt_r == 5'(PMR_TA_BITS - 1))
                    begin
                        bit_cnt_r <= 5'h00;
                        fr_r      <= PMR_FR_WR;
                    end
                end
                PMR_FR_RD:
                begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (rd_end)
                    begin
                        drive_r    <= 1'b0;
                        mdio_out_r <= 1'b1;
                        fr_r       <= PMR_FR_PRE;
                    end
                    else
                    begin
                        mdio_out_r <= rd_shift_r[PMR_DATA_BITS-1];
                        rd_shift_r <= {rd_shift_r[14:0], 1'b0};
                    end
                end
                PMR_FR_WR:
                begin
                    wr_shift_r <= wr_data[14:0];
                    bit_cnt_r  <= bit_cnt_r + 5'h01;
                    if (wr_commit)
                    begin
                        fr_r <= PMR_FR_PRE;
                    end
                end
                default:
                begin
                    fr_r <= PMR_FR_PRE;
                end
            endcase
        end
    end

    assign mdio_out  = mdio_out_r;
    assign mdio_oe_n = ~drive_r;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic ctl_wr;
    logic sts_wr;

    assign ctl_wr  = wr_commit && (reg_r == PMR_REG_CONTROL);
    assign sts_wr  = wr_commit && (reg_r == PMR_REG_STATUS);
    assign sr_busy = (sr_cnt_r != SR_W'(0));
    assign an_en   = an_pin_s & an_sw_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sr_cnt_r <= SR_W'(0);
            loop_r   <= PMR_LOOP_RST;
            speed_r  <= PMR_SPEED_RST;
            an_sw_r  <= PMR_AN_EN_RST;
            iso_r    <= PMR_ISO_RST;
            dup_r    <= PMR_DUPLEX_RST;
        end
        else if (clk_en)
        begin
            if (sr_busy)
            begin
                sr_cnt_r <= sr_cnt_r - SR_W'(1);
            end
            else if (ctl_wr && wr_data[PMR_CTL_SRESET])
            begin
                // soft reset restores defaults and drops the rest of this write
                sr_cnt_r <= SR_W'(SRESET_CYCLES);
                loop_r   <= PMR_LOOP_RST;
                speed_r  <= PMR_SPEED_RST;
                an_sw_r  <= PMR_AN_EN_RST;
                iso_r    <= PMR_ISO_RST;
                dup_r    <= PMR_DUPLEX_RST;
            end
            else if (ctl_wr)
            begin
                loop_r  <= wr_data[PMR_CTL_LOOP];
                speed_r <= wr_data[PMR_CTL_SPEED];
                iso_r   <= wr_data[PMR_CTL_ISOLATE];
                if (an_pin_s)
                begin
                    an_sw_r <= wr_data[PMR_CTL_AN_EN];
                end
                if (!wr_data[PMR_CTL_DUPLEX] || !an_en)
                begin
                    dup_r <= wr_data[PMR_CTL_DUPLEX];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // autoneg restart pulse
    // ----------------------------------------------------------------
    logic restart_req;

    assign restart_req = (ctl_wr && !sr_busy && wr_data[PMR_CTL_AN_RST]
                          && !wr_data[PMR_CTL_SRESET]) || aux_restart_req;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            an_rst_cnt_r <= 2'h0;
        end
        else if (clk_en)
        begin
            if (restart_req && an_en)
            begin
                an_rst_cnt_r <= 2'(PMR_AN_RST_CYCLES);
            end
            else if (an_rst_cnt_r != 2'h0)
            begin
                an_rst_cnt_r <= an_rst_cnt_r - 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // status register: writable bit and latched events
    // ----------------------------------------------------------------
    logic rd_sts;

    assign rd_sts = rd_start && (hdr_nxt[4:0] == PMR_REG_STATUS);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pre_sup_r <= PMR_PRE_RST;
        end
        else if (clk_en && sts_wr)
        begin
            pre_sup_r <= wr_data[PMR_STS_PRE_SUP];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            snap_r <= 3'h0;
        end
        else if (clk_en)
        begin
            if (rd_sts)
            begin
                snap_r <= {rf_r, link_low_r, jab_r};
            end
            else if (rd_end)
            begin
                snap_r <= 3'h0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rf_r        <= 1'b0;
            link_low_r  <= 1'b0;
            jab_r       <= 1'b0;
            link_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            link_prev_r <= line.link_pass;
            // set wins over clear; clear only what the read reported
            rf_r <= (line.fiber_mode && line.far_fault)
                    || (rf_r && !(rd_end && snap_r[2] && !line.far_fault));
            link_low_r <= (link_prev_r && !line.link_pass)
                          || (link_low_r && !(rd_end && snap_r[1]));
            jab_r <= (line.ten_base_t && line.jabber)
                     || (jab_r && !(rd_end && snap_r[0]));
        end
    end

    // ----------------------------------------------------------------
    // read values and outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        ctl_rd                  = PMR_ZERO16;
        ctl_rd[PMR_CTL_SRESET]  = sr_busy;
        ctl_rd[PMR_CTL_LOOP]    = loop_r;
        ctl_rd[PMR_CTL_SPEED]   = speed_r;
        ctl_rd[PMR_CTL_AN_EN]   = an_sw_r;
        ctl_rd[PMR_CTL_PWRDN]   = 1'b0;
        ctl_rd[PMR_CTL_ISOLATE] = iso_r;
        ctl_rd[PMR_CTL_AN_RST]  = 1'b0;
        ctl_rd[PMR_CTL_DUPLEX]  = dup_r;
    end

    always_comb
    begin
        sts_rd                  = PMR_STS_CAPS;
        sts_rd[PMR_STS_PRE_SUP] = pre_sup_r;
        sts_rd[PMR_STS_AN_DONE] = line.an_complete && an_en;
        sts_rd[PMR_STS_RFAULT]  = rf_r;
        sts_rd[PMR_STS_LINK]    = line.link_pass && !link_low_r;
        sts_rd[PMR_STS_JABBER]  = jab_r;
    end

    always_comb
    begin
        ctrl.soft_reset        = sr_busy;
        ctrl.loopback          = loop_r;
        ctrl.an_enabled        = an_en;
        ctrl.an_restart        = (an_rst_cnt_r != 2'h0);
        ctrl.speed_100         = an_en ? 1'b1 : speed_r;
        ctrl.full_duplex       = dup_r;
        ctrl.isolate           = iso_r;
        ctrl.preamble_suppress = pre_sup_r;
    end

endmodule : pmr_regs

// ---- testbench/pmr_host_model.sv ----
// station management controller model issuing framed reads and writes
// assumes mdio is the wired line with a pull-up; clk is the 25 MHz device clock
`timescale 1ns/1ps
module pmr_host_model
    import pmr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h03
)
(
    input  wire logic clk,
    input  wire logic mdio,
    output logic      mdc,
    output logic      mdio_drv
);
    // ------------------------------------------------------------
    // frame engine: five clocks per mdc phase, data set while mdc low
    // ------------------------------------------------------------
    initial
    begin
        mdc      = 1'b0;
        mdio_drv = 1'b1;
    end

    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         input int pre, output logic [15:0] rd);
        logic        wr;
        logic [31:0] bits;
        wr   = (op == PMR_OP_WRITE);
        // turnaround and read data are released to the pull-up
        bits = {2'b01, op, PHY_ADDR, ra, wr ? 2'b10 : 2'b11, wr ? wd : 16'hFFFF};
        for (int i = 0; i < pre + 32; i++)
        begin
            mdio_drv = (i < pre) ? 1'b1 : bits[31 - (i - pre)];
            repeat (5) @(negedge clk);
            if (i >= pre + 16)
                rd[pre + 31 - i] = mdio;
            mdc = 1'b1;
            repeat (5) @(negedge clk);
            mdc = 1'b0;
        end
        mdio_drv = 1'b1;
    endtask : frame
endmodule : pmr_host_model

// ---- testbench/pmr_regs_asserts.sv ----
// checker for the phy management register block, bound to its ports
// assumes clk_en held high by the surrounding bench
`timescale 1ns/1ps
module pmr_regs_checker
    import pmr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR      = 5'h00,
    parameter int         SRESET_CYCLES = PMR_SRESET_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic autoneg_enable_pin,
    input wire logic aux_restart_req,
    input pmr_line_s line,
    input pmr_ctrl_s ctrl
);
    int sr_cnt_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            sr_cnt_r <= 0;
        else if (ctrl.soft_reset)
            sr_cnt_r <= sr_cnt_r + 1;
        else
            sr_cnt_r <= 0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_restart_pulse_len: assert property (
        $rose(ctrl.an_restart) |=> ctrl.an_restart ##1 !ctrl.an_restart)
        else $error("restart pulse length wrong");
    a_restart_needs_an: assert property (
        ctrl.an_restart |-> ctrl.an_enabled) else $error("restart without autoneg");
    a_aux_restart_acts: assert property (
        aux_restart_req && ctrl.an_enabled && !ctrl.an_restart |-> ##[1:3] ctrl.an_restart)
        else $error("aux restart lost");
    a_speed_when_an: assert property (
        ctrl.an_enabled |-> ctrl.speed_100) else $error("forced speed under autoneg");
    a_duplex_forced_only: assert property (
        $rose(ctrl.full_duplex) |-> !ctrl.an_enabled) else $error("duplex forced under autoneg");
    a_pin_disables_an: assert property (
        !autoneg_enable_pin [*6] |-> !ctrl.an_enabled) else $error("pin does not disable");
    a_sreset_length: assert property (
        $fell(ctrl.soft_reset) |-> sr_cnt_r >= SRESET_CYCLES - 1 && sr_cnt_r <= SRESET_CYCLES + 1)
        else $error("soft reset length wrong");
    a_sreset_freezes: assert property (
        ctrl.soft_reset && $past(ctrl.soft_reset) |->
        $stable(ctrl.loopback) && $stable(ctrl.isolate) && $stable(ctrl.full_duplex))
        else $error("control moved during soft reset");

    c_soft_reset: cover property ($rose(ctrl.soft_reset));
    c_restart: cover property ($rose(ctrl.an_restart));
    c_read_drive: cover property ($fell(mdio_oe_n));
    c_full_duplex: cover property ($rose(ctrl.full_duplex));
endmodule : pmr_regs_checker

bind pmr_regs pmr_regs_checker #(.PHY_ADDR(PHY_ADDR), .SRESET_CYCLES(SRESET_CYCLES)) u_checker (
    .clk(clk), .reset(reset), .clk_en(clk_en), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .autoneg_enable_pin(autoneg_enable_pin),
    .aux_restart_req(aux_restart_req), .line(line), .ctrl(ctrl));

// ---- testbench/testbench.sv ----
// bench for the phy management registers: framed accesses, pin, line and aux stimulus
// assumes the host model owns mdc and releases mdio to the pull-up level
`timescale 1ns/1ps
module testbench
    import pmr_pkg::*;
;
    localparam logic [15:0] CM = 16'hFF00;
    localparam logic [15:0] SM = 16'hF87F;
    logic        clk;
    logic        reset;
    logic        pin;
    logic        aux;
    logic        mdc;
    logic        drv;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic        mdio;
    pmr_line_s   line;
    pmr_ctrl_s   ctrl;
    logic [15:0] rd;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          restarts = 0;
    int          pre_len = 32;

    assign mdio = drv & (mdio_oe_n | mdio_out);

    pmr_regs #(.PHY_ADDR(5'h03), .SRESET_CYCLES(800)) u_dut (
        .clk(clk), .reset(reset), .clk_en(1'b1), .mdc(mdc), .mdio_in(mdio),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .autoneg_enable_pin(pin),
        .aux_restart_req(aux), .line(line), .ctrl(ctrl));
    pmr_host_model #(.PHY_ADDR(5'h03)) u_host (.clk(clk), .mdio(mdio), .mdc(mdc), .mdio_drv(drv));

    always @(posedge ctrl.an_restart) restarts++;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        samples_checked++;
        if ((got & m) !== (exp & m))
        begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got & m, exp & m);
        end
    endtask : chk

    task automatic nap(input int n);
        repeat (n) @(negedge clk);
    endtask : nap

    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp, input logic [15:0] m);
        u_host.frame(PMR_OP_READ, ra, 16'h0000, pre_len, rd);
        chk(rd, exp, m);
    endtask : rd_reg

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        u_host.frame(PMR_OP_WRITE, ra, wd, pre_len, rd);
    endtask : wr

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // scenarios; ctrl word bits: sreset loop an restart speed fdx iso pre
    // ------------------------------------------------------------
    task automatic t_forcing;
        int n;
        // loopback set-up of the far-side helper registers, which this block ignores
        wr(5'h18, 16'h4000);
        wr(5'h10, 16'h2000);
        wr(PMR_REG_CONTROL, 16'h4400);
        rd_reg(PMR_REG_CONTROL, 16'h4400, CM);
        chk(16'(ctrl), 16'h0042, 16'h006A);
        n = restarts;
        wr(PMR_REG_CONTROL, 16'h2300);
        rd_reg(PMR_REG_CONTROL, 16'h2100, CM);
        chk(16'(ctrl), 16'h000C, 16'h007E);
        wr(PMR_REG_CONTROL, 16'h3000);
        wr(PMR_REG_CONTROL, 16'h3200);
        rd_reg(PMR_REG_CONTROL, 16'h3000, CM);
        chk(16'(ctrl), 16'h0028, 16'h002C);
        chk(16'(restarts - n), 16'h0001, 16'hFFFF);
    endtask : t_forcing

    task automatic t_pin_aux;
        int n;
        pin = 1'b0;
        nap(8);
        wr(PMR_REG_CONTROL, 16'h2000);
        rd_reg(PMR_REG_CONTROL, 16'h3000, CM);
        chk(16'(ctrl), 16'h0000, 16'h0020);
        n = restarts;
        aux = 1'b1;
        nap(1);
        aux = 1'b0;
        nap(4);
        pin = 1'b1;
        nap(8);
        chk(16'(ctrl), 16'h0020, 16'h0020);
        aux = 1'b1;
        nap(1);
        aux = 1'b0;
        nap(4);
        chk(16'(restarts - n), 16'h0001, 16'hFFFF);
    endtask : t_pin_aux

    task automatic t_sreset;
        wr(PMR_REG_CONTROL, 16'h0400);
        wr(PMR_REG_CONTROL, 16'h8000);
        nap(4);
        chk(16'(ctrl), 16'h0080, 16'h0080);
        wr(PMR_REG_CONTROL, 16'h4400);
        rd_reg(PMR_REG_CONTROL, 16'h3000, CM);
    endtask : t_sreset

    task automatic t_status;
        wr(PMR_REG_STATUS, 16'h0040);
        pre_len = 2;
        rd_reg(PMR_REG_STATUS, 16'h7849, SM);
        chk(16'(ctrl), 16'h0001, 16'h0001);
        wr(PMR_REG_STATUS, 16'h0000);
        pre_len = 32;
        // link, autoneg done, fiber and 10BASE-T modes
        line = 6'b100111;
        nap(2);
        rd_reg(PMR_REG_STATUS, 16'h782D, SM);
        line.link_pass = 1'b0;
        line.jabber    = 1'b1;
        line.far_fault = 1'b1;
        nap(2);
        line.link_pass = 1'b1;
        line.jabber    = 1'b0;
        nap(2);
        rd_reg(PMR_REG_STATUS, 16'h783B, SM);
        line.far_fault = 1'b0;
        nap(2);
        rd_reg(PMR_REG_STATUS, 16'h783D, SM);
        rd_reg(PMR_REG_STATUS, 16'h782D, SM);
    endtask : t_status

    task automatic t_defaults;
        chk(16'(ctrl), 16'h0028, 16'h00FF);
        rd_reg(PMR_REG_CONTROL, 16'h3000, CM);
        rd_reg(PMR_REG_STATUS, 16'h7809, SM);
        rd_reg(5'h02, 16'h0000, 16'hFFFF);
    endtask : t_defaults

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        reset = 1'b1;
        pin   = 1'b1;
        aux   = 1'b0;
        line  = '0;
        nap(16);
        reset = 1'b0;
        nap(8);
        t_defaults();
        t_forcing();
        t_pin_aux();
        t_sreset();
        t_status();
        finish_test();
    end
endmodule : testbench
